/* rtl/crs_pkg.sv */
// Constants, carriers and state layout for the processor register set.
// Assumes an APB slave port with 32-bit data and word-aligned registers.
package crs_pkg;

    // ********************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] IDX_DATA0 = 5'h00;
    localparam logic [IDX_W-1:0] IDX_DATA1 = 5'h01;
    localparam logic [IDX_W-1:0] IDX_DATA2 = 5'h02;
    localparam logic [IDX_W-1:0] IDX_DATA3 = 5'h03;
    localparam logic [IDX_W-1:0] IDX_ADDR0 = 5'h04;
    localparam logic [IDX_W-1:0] IDX_ADDR1 = 5'h05;
    localparam logic [IDX_W-1:0] IDX_FRAME = 5'h06;
    localparam logic [IDX_W-1:0] IDX_VTB = 5'h07;
    localparam logic [IDX_W-1:0] IDX_PC = 5'h08;
    localparam logic [IDX_W-1:0] IDX_USP = 5'h09;
    localparam logic [IDX_W-1:0] IDX_ISP = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_SB = 5'h0B;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 5'h0C;
    localparam logic [IDX_W-1:0] IDX_ACT_SP = 5'h0D;
    localparam logic [IDX_W-1:0] IDX_WIDE_LOW = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_WIDE_HIGH = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_WIDE_ADDR = 5'h10;
    localparam int NUM_BANKED = 7;

    // ********************************************************
    // Field layout and reset values
    // ********************************************************
    localparam int FLG_RSV_BIT = 8;
    localparam int FLG_IPL_LSB = 12;
    localparam int SW_INT_LAST = 31;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_ADDR20 = 20'h00000;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [2:0] processor_priority_level;
        logic u;
        logic i;
        logic o;
        logic b;
        logic s;
        logic z;
        logic d;
        logic c;
    } crs_flags_s;

    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] sel;
        logic [3:0] strb;
        logic [31:0] data;
    } crs_wr_s;

    typedef struct packed {
        logic upd;
        logic upd_c;
        logic upd_z;
        logic upd_s;
        logic upd_o;
        logic byte_op;
        logic [15:0] result;
        logic carry;
        logic ovf;
    } crs_alu_s;

    typedef struct packed {
        logic hw_accept;
        logic sw_exec;
        logic [5:0] sw_num;
        logic req;
        logic [2:0] req_prio;
    } crs_irq_s;

    typedef struct packed {
        logic [1:0][NUM_BANKED-1:0][15:0] bank;
        logic [19:0] vtb;
        logic [19:0] pc;
        logic [15:0] user_stack_pointer;
        logic [15:0] interrupt_stack_pointer;
        logic [15:0] sb;
        crs_flags_s processor_status_flags;
        logic [31:0] prdata;
        logic [31:0] dp_rd;
    } crs_state_s;

endpackage

/* rtl/crs_regset.sv */
// Architectural register set and status flags of the processor core.
// Assumes the instruction datapath and interrupt logic drive the request
// ports synchronously to pclk, and an APB master reaches the registers.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps

module crs_regset
    import crs_pkg::*;
#(
    parameter int PADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crs_wr_s dp_wr,
    input wire logic dp_rd_en,
    input wire logic [IDX_W-1:0] dp_rd_sel,
    output logic [31:0] dp_rd_data,
    input wire crs_alu_s alu,
    input wire crs_irq_s irq,
    output logic int_allowed,
    output crs_flags_s flags,
    output logic [19:0] program_counter,
    output logic [19:0] vector_table_base,
    output logic [15:0] active_sp,
    output logic [15:0] static_base,
    output logic [15:0] frame_base
);

    // ********************************************************
    // Helper functions
    // ********************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = nw[15:8];
        end
    endfunction

    function automatic logic idx_ok(input logic [IDX_W-1:0] idx);
        idx_ok = (idx <= IDX_WIDE_ADDR);
    endfunction

    // Read view of one index; banked registers follow the live bank flag
    function automatic logic [31:0] rd_word(input crs_state_s s, input logic [IDX_W-1:0] idx);
        logic bk;
        bk = s.processor_status_flags.b;
        rd_word = 32'h0000_0000;
        unique case (idx)
            IDX_DATA0, IDX_DATA1, IDX_DATA2, IDX_DATA3, IDX_ADDR0, IDX_ADDR1, IDX_FRAME: begin
                rd_word[15:0] = s.bank[bk][idx[2:0]];
            end
            IDX_VTB: rd_word[19:0] = s.vtb;
            IDX_PC: rd_word[19:0] = s.pc;
            IDX_USP: rd_word[15:0] = s.user_stack_pointer;
            IDX_ISP: rd_word[15:0] = s.interrupt_stack_pointer;
            IDX_SB: rd_word[15:0] = s.sb;
            IDX_FLAGS: begin
                // Reserved bit reads as zero, one allowed undefined value
                rd_word[7:0] = s.processor_status_flags[7:0];
                rd_word[FLG_IPL_LSB+:3] = s.processor_status_flags.processor_priority_level;
            end
            IDX_ACT_SP: rd_word[15:0] = s.processor_status_flags.u ? s.user_stack_pointer : s.interrupt_stack_pointer;
            IDX_WIDE_LOW: rd_word = {s.bank[bk][2], s.bank[bk][0]};
            IDX_WIDE_HIGH: rd_word = {s.bank[bk][3], s.bank[bk][1]};
            IDX_WIDE_ADDR: rd_word = {s.bank[bk][5], s.bank[bk][4]};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    // Byte-strobed write into one index
    function automatic crs_state_s apply_wr(input crs_state_s s, input logic [IDX_W-1:0] idx,
                                            input logic [31:0] d, input logic [3:0] strb);
        logic bk;
        apply_wr = s;
        bk = s.processor_status_flags.b;
        unique case (idx)
            IDX_DATA0, IDX_DATA1, IDX_DATA2, IDX_DATA3, IDX_ADDR0, IDX_ADDR1, IDX_FRAME: begin
                // Byte lanes give the upper and lower halves of each register
                apply_wr.bank[bk][idx[2:0]] =
                    merge16(s.bank[bk][idx[2:0]], d[15:0], strb[1:0]);
            end
            IDX_VTB: begin
                apply_wr.vtb[15:0] = merge16(s.vtb[15:0], d[15:0], strb[1:0]);
                if (strb[2]) begin
                    apply_wr.vtb[19:16] = d[19:16];
                end
            end
            IDX_PC: begin
                apply_wr.pc[15:0] = merge16(s.pc[15:0], d[15:0], strb[1:0]);
                if (strb[2]) begin
                    apply_wr.pc[19:16] = d[19:16];
                end
            end
            IDX_USP: apply_wr.user_stack_pointer = merge16(s.user_stack_pointer, d[15:0], strb[1:0]);
            IDX_ISP: apply_wr.interrupt_stack_pointer = merge16(s.interrupt_stack_pointer, d[15:0], strb[1:0]);
            IDX_SB: apply_wr.sb = merge16(s.sb, d[15:0], strb[1:0]);
            IDX_FLAGS: begin
                // Reserved bit has no storage; written value is dropped
                if (strb[0]) begin
                    apply_wr.processor_status_flags[7:0] = d[7:0];
                end
                if (strb[1]) begin
                    apply_wr.processor_status_flags.processor_priority_level = d[FLG_IPL_LSB+:3];
                end
            end
            IDX_ACT_SP: begin
                if (s.processor_status_flags.u) begin
                    apply_wr.user_stack_pointer = merge16(s.user_stack_pointer, d[15:0], strb[1:0]);
                end else begin
                    apply_wr.interrupt_stack_pointer = merge16(s.interrupt_stack_pointer, d[15:0], strb[1:0]);
                end
            end
            IDX_WIDE_LOW: begin
                apply_wr.bank[bk][0] = merge16(s.bank[bk][0], d[15:0], strb[1:0]);
                apply_wr.bank[bk][2] = merge16(s.bank[bk][2], d[31:16], strb[3:2]);
            end
            IDX_WIDE_HIGH: begin
                apply_wr.bank[bk][1] = merge16(s.bank[bk][1], d[15:0], strb[1:0]);
                apply_wr.bank[bk][3] = merge16(s.bank[bk][3], d[31:16], strb[3:2]);
            end
            IDX_WIDE_ADDR: begin
                apply_wr.bank[bk][4] = merge16(s.bank[bk][4], d[15:0], strb[1:0]);
                apply_wr.bank[bk][5] = merge16(s.bank[bk][5], d[31:16], strb[3:2]);
            end
            default: apply_wr = s;
        endcase
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    // Thirteen registers: seven banked (twice), six unbanked incl. flags
    crs_state_s st_q;
    crs_state_s st_d;
    logic [IDX_W-1:0] apb_idx;
    logic apb_hit;
    logic apb_wr;
    logic apb_rd_setup;
    logic alu_zero;
    logic alu_neg;

    assign apb_idx = paddr[IDX_W+1:2];
    assign apb_hit = idx_ok(apb_idx) && (paddr[PADDR_W-1:IDX_W+2] == '0) && (paddr[1:0] == 2'b00);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd_setup = psel && !penable && !pwrite;
    assign alu_zero = alu.byte_op ? (alu.result[7:0] == 8'h00) : (alu.result == 16'h0000);
    assign alu_neg = alu.byte_op ? alu.result[7] : alu.result[15];

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_d = st_q;
        // Read data is taken at setup so the access phase never waits
        if (apb_rd_setup) begin
            st_d.prdata = apb_hit ? rd_word(st_q, apb_idx) : 32'h0000_0000;
        end
        if (apb_wr && apb_hit) begin
            st_d = apply_wr(st_d, apb_idx, pwdata, pstrb);
        end
        // Datapath follows the bus so it wins a same-cycle collision
        if (dp_wr.en && idx_ok(dp_wr.sel)) begin
            st_d = apply_wr(st_d, dp_wr.sel, dp_wr.data, dp_wr.strb);
        end
        if (dp_rd_en) begin
            st_d.dp_rd = rd_word(st_q, dp_rd_sel);
        end
        if (alu.upd) begin
            if (alu.upd_c) begin
                st_d.processor_status_flags.c = alu.carry;
            end
            if (alu.upd_z) begin
                st_d.processor_status_flags.z = alu_zero;
            end
            if (alu.upd_s) begin
                st_d.processor_status_flags.s = alu_neg;
            end
            if (alu.upd_o) begin
                st_d.processor_status_flags.o = alu.ovf;
            end
        end
        // Interrupt events override any write to U or I in the same cycle
        if (irq.hw_accept) begin
            st_d.processor_status_flags.i = 1'b0;
            st_d.processor_status_flags.u = 1'b0;
        end
        if (irq.sw_exec && (irq.sw_num <= 6'(SW_INT_LAST))) begin
            st_d.processor_status_flags.u = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    assign prdata = st_q.prdata;
    assign dp_rd_data = st_q.dp_rd;
    assign int_allowed = irq.req && st_q.processor_status_flags.i && (irq.req_prio > st_q.processor_status_flags.processor_priority_level);
    assign flags = st_q.processor_status_flags;
    assign program_counter = st_q.pc;
    assign vector_table_base = st_q.vtb;
    assign active_sp = st_q.processor_status_flags.u ? st_q.user_stack_pointer : st_q.interrupt_stack_pointer;
    assign static_base = st_q.sb;
    assign frame_base = st_q.bank[st_q.processor_status_flags.b][3'(IDX_FRAME)];

    // ********************************************************
    // Assertions
    // ********************************************************
    logic [15:0] bank_data0;
    logic [15:0] bank_other0;
    assign bank_data0 = st_q.bank[st_q.processor_status_flags.b][0];
    assign bank_other0 = st_q.bank[~st_q.processor_status_flags.b][0];

    property p_stack_sel;
        @(posedge pclk) disable iff (!presetn)
        (st_q.processor_status_flags.u == 1'b0) |-> (active_sp == st_q.interrupt_stack_pointer);
    endproperty
    a_stack_sel: assert property (p_stack_sel) else $error("stack select wrong");

    property p_hw_accept;
        @(posedge pclk) disable iff (!presetn)
        irq.hw_accept |=> (!flags.u && !flags.i);
    endproperty
    a_hw_accept: assert property (p_hw_accept) else $error("accept left U or I set");

    property p_sw_int;
        @(posedge pclk) disable iff (!presetn)
        (irq.sw_exec && irq.sw_num < 6'd32) |=> !flags.u;
    endproperty
    a_sw_int: assert property (p_sw_int) else $error("software interrupt left U set");

    property p_carry;
        @(posedge pclk) disable iff (!presetn)
        (alu.upd && alu.upd_c) |=> (flags.c == $past(alu.carry));
    endproperty
    a_carry: assert property (p_carry) else $error("carry not captured");

    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        (alu.upd && alu.upd_z) |=> (flags.z == $past(alu_zero));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sign;
        @(posedge pclk) disable iff (!presetn)
        (alu.upd && alu.upd_s && !alu.byte_op) |=> (flags.s == $past(alu.result[15]));
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");

    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        (alu.upd && alu.upd_o) |=> (flags.o == $past(alu.ovf));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        int_allowed |-> (flags.i && irq.req_prio > flags.processor_priority_level);
    endproperty
    a_prio: assert property (p_prio) else $error("interrupt passed gate");

    property p_byte_half;
        @(posedge pclk) disable iff (!presetn)
        (dp_wr.en && dp_wr.sel == IDX_DATA0 && dp_wr.strb == 4'h1 && !apb_wr)
        |=> (bank_data0[15:8] == $past(bank_data0[15:8])
             && bank_data0[7:0] == $past(dp_wr.data[7:0]));
    endproperty
    a_byte_half: assert property (p_byte_half) else $error("byte half write wrong");

    property p_bank;
        @(posedge pclk) disable iff (!presetn)
        (dp_wr.en && dp_wr.sel == IDX_DATA0 && dp_wr.strb == 4'h3 && !apb_wr
         && !irq.hw_accept)
        |=> (bank_other0 == $past(bank_other0));
    endproperty
    a_bank: assert property (p_bank) else $error("hidden bank disturbed");

    property p_bank_read;
        @(posedge pclk) disable iff (!presetn)
        (dp_rd_en && dp_rd_sel == IDX_DATA0) |=> (dp_rd_data[15:0] == $past(bank_data0));
    endproperty
    a_bank_read: assert property (p_bank_read) else $error("read from wrong bank");

    property p_rsv;
        @(posedge pclk) disable iff (!presetn)
        (apb_rd_setup && apb_hit && apb_idx == IDX_FLAGS) |=> (prdata[11:8] == 4'h0);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag bits not zero");

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        (!alu.upd && !apb_wr && !dp_wr.en && !irq.hw_accept && !irq.sw_exec)
        |=> (flags == $past(flags));
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags changed unprompted");

    property p_flag_write;
        @(posedge pclk) disable iff (!presetn)
        (apb_wr && apb_hit && apb_idx == IDX_FLAGS && pstrb[0] && !dp_wr.en && !alu.upd
         && !irq.hw_accept && !irq.sw_exec)
        |=> (flags[7:0] == $past(pwdata[7:0]));
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write lost");

    property p_pc_hold;
        @(posedge pclk) disable iff (!presetn)
        (!apb_wr && !dp_wr.en) |=> (program_counter == $past(program_counter));
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("program counter drifted");

    property p_user_sp;
        @(posedge pclk) disable iff (!presetn)
        (st_q.processor_status_flags.u == 1'b1) |-> (active_sp == st_q.user_stack_pointer);
    endproperty
    a_user_sp: assert property (p_user_sp) else $error("user stack not selected");

    property p_int_mask;
        @(posedge pclk) disable iff (!presetn)
        (!flags.i || !irq.req) |-> !int_allowed;
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("masked request passed");

    property p_sw_high;
        @(posedge pclk) disable iff (!presetn)
        (irq.sw_exec && irq.sw_num > 6'd31 && !irq.hw_accept && !apb_wr && !dp_wr.en)
        |=> (flags.u == $past(flags.u));
    endproperty
    a_sw_high: assert property (p_sw_high) else $error("high number cleared U");

    property p_rd_refused;
        @(posedge pclk) disable iff (!presetn)
        (dp_rd_en && !idx_ok(dp_rd_sel)) |=> (dp_rd_data == 32'h0000_0000);
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("refused read not zero");

endmodule

/* test/crs_dp_model.sv */
// Behavioural model of the instruction datapath and interrupt logic.
// Assumes the bench calls its tasks from a single process on pclk.
`timescale 1ns/10ps

module crs_dp_model
    import crs_pkg::*;
(
    input wire logic pclk,
    output crs_wr_s dp_wr,
    output logic dp_rd_en,
    output logic [IDX_W-1:0] dp_rd_sel,
    input wire logic [31:0] dp_rd_data,
    output crs_alu_s alu,
    output crs_irq_s irq
);
    initial begin
        dp_wr = '0;
        dp_rd_en = 1'b0;
        dp_rd_sel = '0;
        alu = '0;
        irq = '0;
    end

    // Released fields are inverted so stale values cannot pass for live ones
    task automatic dp_write(input logic [IDX_W-1:0] sel, input logic [3:0] strb,
                            input logic [31:0] data);
        @(posedge pclk);
        dp_wr <= '{en: 1'b1, sel: sel, strb: strb, data: data};
        @(posedge pclk);
        dp_wr <= '{en: 1'b0, sel: ~sel, strb: ~strb, data: ~data};
    endtask

    task automatic dp_read(input logic [IDX_W-1:0] sel, output logic [31:0] data);
        @(posedge pclk);
        dp_rd_en <= 1'b1;
        dp_rd_sel <= sel;
        @(posedge pclk);
        dp_rd_en <= 1'b0;
        dp_rd_sel <= ~sel;
        @(posedge pclk);
        data = dp_rd_data;
    endtask

    task automatic alu_op(input logic bop, input logic [15:0] r, input logic c,
                          input logic o);
        @(posedge pclk);
        alu <= '{upd: 1'b1, upd_c: 1'b1, upd_z: 1'b1, upd_s: 1'b1, upd_o: 1'b1,
                 byte_op: bop, result: r, carry: c, ovf: o};
        @(posedge pclk);
        alu <= '{upd: 1'b0, upd_c: 1'b0, upd_z: 1'b0, upd_s: 1'b0, upd_o: 1'b0,
                 byte_op: ~bop, result: ~r, carry: ~c, ovf: ~o};
    endtask

    task automatic irq_pulse(input logic hw, input logic sw, input logic [5:0] num);
        @(posedge pclk);
        irq.hw_accept <= hw;
        irq.sw_exec <= sw;
        irq.sw_num <= num;
        @(posedge pclk);
        irq.hw_accept <= 1'b0;
        irq.sw_exec <= 1'b0;
        irq.sw_num <= ~num;
    endtask

    task automatic set_req(input logic rq, input logic [2:0] prio);
        @(posedge pclk);
        irq.req <= rq;
        irq.req_prio <= prio;
    endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the processor register set.
// Assumes the APB master here and the datapath model drive all inputs.
`timescale 1ns/10ps

module tb
    import crs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, dp_rd_data;
    logic pready, pslverr, dp_rd_en, int_allowed;
    logic [IDX_W-1:0] dp_rd_sel;
    crs_wr_s dp_wr;
    crs_alu_s alu;
    crs_irq_s irq;
    crs_flags_s flags;
    logic [19:0] program_counter, vector_table_base;
    logic [15:0] active_sp, static_base, frame_base;
    int err_count = 0;
    int num_checks = 0;
    localparam logic [4:0] LO_I [3] = '{IDX_DATA0, IDX_DATA1, IDX_ADDR0};
    localparam logic [4:0] HI_I [3] = '{IDX_DATA2, IDX_DATA3, IDX_ADDR1};
    localparam logic [4:0] WD_I [3] = '{IDX_WIDE_LOW, IDX_WIDE_HIGH, IDX_WIDE_ADDR};
    localparam logic [5:0] SW_N [3] = '{6'h00, 6'h1F, 6'h20};

    always #50 pclk = ~pclk;

    crs_regset #(.PADDR_W(8)) i_crs_regset (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_wr(dp_wr),
        .dp_rd_en(dp_rd_en), .dp_rd_sel(dp_rd_sel), .dp_rd_data(dp_rd_data), .alu(alu),
        .irq(irq), .int_allowed(int_allowed), .flags(flags),
        .program_counter(program_counter), .vector_table_base(vector_table_base),
        .active_sp(active_sp), .static_base(static_base), .frame_base(frame_base));

    crs_dp_model i_crs_dp_model (.pclk(pclk), .dp_wr(dp_wr), .dp_rd_en(dp_rd_en),
        .dp_rd_sel(dp_rd_sel), .dp_rd_data(dp_rd_data), .alu(alu), .irq(irq));

    // ****************************************************
    // Expectations, compare and bus tasks
    // ****************************************************
    function automatic logic [31:0] reg_mask(input logic [4:0] idx);
        if (idx == IDX_VTB || idx == IDX_PC) return 32'h000FFFFF;
        if (idx == IDX_FLAGS) return 32'h000070FF;
        if (idx >= IDX_WIDE_LOW) return 32'hFFFFFFFF;
        return 32'h0000FFFF;
    endfunction

    // Debug and reserved bits always written as zero
    function automatic logic [31:0] flags_word(input logic [2:0] processor_priority_level, input logic u,
                                               input logic i, input logic b);
        return {17'h0, processor_priority_level, 4'h0, u, i, 1'b0, b, 4'h0};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [4:0] idx, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        logic [31:0] t;
        logic e;
        apb(1'b1, idx, d, 4'hF, t, e);
    endtask

    task automatic rdchk(input logic [4:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h0, 4'h0, d, e);
        check(d & reg_mask(idx), exp);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #3000000;
        err_count++;
        complete_run();
    end

    // ****************************************************
    // Test sequence
    // ****************************************************
    initial begin
        logic [31:0] v, h, t;
        logic [31:0] mem [13];
        logic [15:0] r;
        logic [2:0] processor_priority_level, pr;
        logic e, bop, ien, rq;
        void'($urandom(32'h5e65f5e4));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k <= 16; k++) rdchk(5'(k), 32'h0);
        apb(1'b0, 5'h11, 32'h0, 4'h0, t, e);
        check(t, 32'h0);
        check(e, 32'h1);
        $display("test reset done");
        for (int k = 0; k <= 12; k++) begin
            v = $urandom() & reg_mask(5'(k));
            if (k == 12) v = v & ~32'h00000102;
            wr(5'(k), v);
            rdchk(5'(k), v);
            mem[k] = v;
        end
        check(program_counter, mem[8]);
        check(vector_table_base, mem[7]);
        check(static_base, mem[11]);
        check(flags, {mem[12][14:12], mem[12][7:0]});
        check(active_sp, mem[12][7] ? mem[9] : mem[10]);
        $display("test random registers done");
        v = $urandom();
        h = $urandom();
        wr(IDX_FLAGS, flags_word(3'h0, 1'b0, 1'b0, 1'b0));
        wr(IDX_DATA0, v[15:0]);
        wr(IDX_FRAME, v[31:16]);
        wr(IDX_FLAGS, flags_word(3'h0, 1'b0, 1'b0, 1'b1));
        wr(IDX_DATA0, h[15:0]);
        wr(IDX_FRAME, h[31:16]);
        rdchk(IDX_DATA0, h[15:0]);
        check(frame_base, h[31:16]);
        wr(IDX_FLAGS, flags_word(3'h0, 1'b0, 1'b0, 1'b0));
        rdchk(IDX_DATA0, v[15:0]);
        check(frame_base, v[31:16]);
        $display("test banks done");
        for (int k = 0; k < 2; k++) begin
            wr(5'(k), 32'h00001234);
            apb(1'b1, 5'(k), 32'h000000AB, 4'b0001, t, e);
            apb(1'b1, 5'(k), 32'h0000CD00, 4'b0010, t, e);
            rdchk(5'(k), 32'h0000CDAB);
        end
        for (int k = 0; k < 3; k++) begin
            v = $urandom();
            wr(LO_I[k], v[15:0]);
            wr(HI_I[k], v[31:16]);
            rdchk(WD_I[k], v);
        end
        v = $urandom();
        i_crs_dp_model.dp_write(IDX_WIDE_ADDR, 4'hF, v);
        rdchk(IDX_ADDR1, v[31:16]);
        rdchk(IDX_ADDR0, v[15:0]);
        i_crs_dp_model.dp_write(IDX_PC, 4'hF, v);
        i_crs_dp_model.dp_read(IDX_PC, t);
        check(t, v & 32'h000FFFFF);
        check(program_counter, v[19:0]);
        h = $urandom();
        i_crs_dp_model.dp_write(IDX_DATA0, 4'h3, h);
        i_crs_dp_model.dp_write(IDX_DATA0, 4'h1, v);
        i_crs_dp_model.dp_read(IDX_DATA0, t);
        check(t, {16'h0, h[15:8], v[7:0]});
        i_crs_dp_model.dp_read(5'h1F, t);
        check(t, 32'h0);
        $display("test halves and pairs done");
        v = $urandom();
        wr(IDX_USP, v[15:0]);
        wr(IDX_ISP, v[31:16]);
        wr(IDX_FLAGS, flags_word(3'h0, 1'b1, 1'b1, 1'b0));
        @(negedge pclk);
        check(active_sp, v[15:0]);
        wr(IDX_ACT_SP, h[15:0]);
        rdchk(IDX_USP, h[15:0]);
        rdchk(IDX_ACT_SP, h[15:0]);
        i_crs_dp_model.irq_pulse(1'b1, 1'b0, 6'h00);
        @(negedge pclk);
        check(flags.u, 32'h0);
        check(flags.i, 32'h0);
        check(active_sp, v[31:16]);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_FLAGS, flags_word(3'h0, 1'b1, 1'b1, 1'b0));
            i_crs_dp_model.irq_pulse(1'b0, 1'b1, SW_N[k]);
            @(negedge pclk);
            check(flags.u, SW_N[k] > 6'd31);
        end
        $display("test stack select done");
        for (int k = 0; k < 24; k++) begin
            v = $urandom();
            r = (k == 0) ? 16'h0000 : (k == 1) ? 16'h8000 : (k == 2) ? 16'h0100 : v[31:16];
            bop = (k == 2) || (k > 2 && v[0]);
            i_crs_dp_model.alu_op(bop, r, v[1], v[2]);
            @(negedge pclk);
            check(flags.c, v[1]);
            check(flags.z, bop ? (r[7:0] == 8'h00) : (r == 16'h0000));
            check(flags.s, bop ? r[7] : r[15]);
            check(flags.o, v[2]);
        end
        $display("test alu flags done");
        for (int k = 0; k < 24; k++) begin
            v = $urandom();
            processor_priority_level = v[2:0];
            pr = (k < 8) ? processor_priority_level : v[5:3];
            ien = v[6] || k < 8;
            rq = v[7] || k < 8;
            wr(IDX_FLAGS, flags_word(processor_priority_level, 1'b0, ien, 1'b0));
            i_crs_dp_model.set_req(rq, pr);
            @(negedge pclk);
            check(flags.processor_priority_level, processor_priority_level);
            check(int_allowed, rq && ien && (pr > processor_priority_level));
        end
        $display("test priority done");
        complete_run();
    end
endmodule
